// *** design/hpsh_core.sv ***
// Device side of the strobe driven parallel host port.
// Assumes host pins are raw asynchronous inputs and that the internal
// fetch and store ports live on mclk.
//
// Operation
// - Access strobe is chip select or xnor strobes
// - First data read fetches; ready high until loaded
// - Data write ready stays high while buffer full
// - Bus driven on reads only, released promptly
// - Read data valid on the same edge ready goes low
// - Second half read served without fetch
`timescale 1ns/1ps
`default_nettype none
module hpsh_core (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    // Host strobes and selects
    input  wire logic                        host_chip_select_n,
    input  wire logic                        data_strobe_one,
    input  wire logic                        data_strobe_two,
    input  wire logic                        addr_strobe_n,
    input  wire logic [1:0]                  access_control_field,
    input  wire logic                        read_not_write,
    input  wire logic                        half_word_select,
    input  wire logic                        half_width_mode,
    // Host data bus and ready
    input  wire logic [hpsh_pkg::DATA_W-1:0] port_data_in,
    output logic      [hpsh_pkg::DATA_W-1:0] port_data_out,
    output logic                             port_data_oe,
    output logic                             host_ready_n,
    // Fetch port of the internal dma engine
    output logic                             fetch_req,
    input  wire logic                        fetch_ack,
    input  wire logic [hpsh_pkg::DATA_W-1:0] fetch_data,
    // Store port into the write buffer
    output logic                             store_valid,
    input  wire logic                        store_ready,
    output logic      [hpsh_pkg::DATA_W-1:0] store_data
);
    import hpsh_pkg::*;

    localparam int RDY2_MAX = HALF2_CYC - SYNC_LAT - 1;

    typedef struct packed {
        hpsh_state_e       st;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] dout;
        logic [DATA_W-1:0] sdata;
        logic              oe;
        logic              rdy_n;
        logic              fetch;
        logic              pend;
        logic [1:0]        acf;
        logic              hw;
        logic              m16;
    } hpsh_core_s;

    hpsh_core_s        q;
    hpsh_core_s        d;
    logic [PIN_W-1:0]  pins;
    logic [DATA_W-1:0] word;

    hpsh_link_if lk ();

    // Pick the half or whole word that goes out on the bus
    function automatic logic [DATA_W-1:0] out_view(
            input logic [DATA_W-1:0] w,
            input logic              m16,
            input logic              hw);
        logic [DATA_W-1:0] v;
        v = w;
        if (m16) begin
            v = {{HALF_W{1'b0}}, hw ? w[DATA_W-1:HALF_W] : w[HALF_W-1:0]};
        end
        return v;
    endfunction

    // ****************************************
    // Pin synchroniser
    // ****************************************
    assign pins = {access_control_field, half_width_mode, half_word_select,
                   read_not_write, addr_strobe_n, data_strobe_two,
                   data_strobe_one, host_chip_select_n, port_data_in};

    hpsh_pin_sync u_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .pins  (pins),
        .lk    (lk.sync)
    );

    // ****************************************
    // Access sequencer
    // ****************************************
    always_comb begin
        d    = q;
        word = q.data;
        if (q.pend && store_ready) begin
            d.pend = 1'b0;
        end
        case (q.st)
            ST_IDLE: begin
                d.rdy_n = 1'b1;
                if (lk.strobe_fall) begin
                    d.acf = lk.sel_acf;
                    d.hw  = lk.sel_hw;
                    d.m16 = lk.mode16;
                    if (lk.sel_rnw) begin
                        d.oe = 1'b1;
                        if (hpsh_is_data(lk.sel_acf) &&
                            hpsh_word_edge(lk.mode16, lk.sel_hw, 1'b1)) begin
                            d.fetch = 1'b1;
                            d.st    = ST_FETCH;
                        end else begin
                            // Held word serves the second half
                            d.dout  = out_view(q.data, lk.mode16, lk.sel_hw);
                            d.rdy_n = 1'b0;
                            d.st    = ST_RD;
                        end
                    end else begin
                        d.st = ST_WR_WAIT;
                    end
                end
            end
            ST_FETCH: begin
                d.rdy_n = 1'b1;
                if (fetch_ack) begin
                    d.fetch = 1'b0;
                    d.data  = fetch_data;
                    d.dout  = out_view(fetch_data, q.m16, q.hw);
                    d.rdy_n = 1'b0;
                    d.st    = ST_RD;
                end
            end
            ST_RD: begin
                if (lk.strobe_rise) begin
                    d.oe    = 1'b0;
                    d.rdy_n = 1'b1;
                    d.st    = ST_IDLE;
                end
            end
            ST_WR_WAIT: begin
                if (!hpsh_is_data(q.acf) || (!q.pend && store_ready)) begin
                    d.rdy_n = 1'b0;
                    d.st    = ST_WR;
                end else begin
                    d.rdy_n = 1'b1;
                end
            end
            ST_WR: begin
                if (lk.strobe_rise) begin
                    if (!q.m16) begin
                        word = lk.wdata;
                    end else if (q.hw) begin
                        word[DATA_W-1:HALF_W] = lk.wdata[HALF_W-1:0];
                    end else begin
                        word[HALF_W-1:0] = lk.wdata[HALF_W-1:0];
                    end
                    if (hpsh_is_data(q.acf)) begin
                        d.data = word;
                        if (hpsh_word_edge(q.m16, q.hw, 1'b0)) begin
                            d.sdata = word;
                            d.pend  = 1'b1;
                        end
                    end
                    d.rdy_n = 1'b1;
                    d.st    = ST_IDLE;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{st: ST_IDLE, data: DATA_RST, dout: DATA_RST,
                   sdata: DATA_RST, rdy_n: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign port_data_out = q.dout;
    assign port_data_oe  = q.oe & lk.strobe_low;
    assign host_ready_n  = q.rdy_n;
    assign fetch_req     = q.fetch;
    assign store_valid   = q.pend;
    assign store_data    = q.sdata;

    // ****************************************
    // Checks
    // ****************************************
    chk_fetch_holds_ready: assert property (@(posedge mclk) disable iff (!rst_b)
        fetch_req |-> host_ready_n)
        else $error("ready low while fetch outstanding");

    chk_fetch_on_first: assert property (@(posedge mclk) disable iff (!rst_b)
        (q.st == ST_IDLE && lk.strobe_fall && lk.sel_rnw &&
         hpsh_is_data(lk.sel_acf) && (!lk.mode16 || !lk.sel_hw))
        |=> fetch_req && host_ready_n)
        else $error("first read did not request a fetch");

    chk_full_not_ready: assert property (@(posedge mclk) disable iff (!rst_b)
        (q.st == ST_WR_WAIT && hpsh_is_data(q.acf) && (q.pend || !store_ready))
        |=> host_ready_n)
        else $error("ready given while write buffer full");

    chk_release_bus: assert property (@(posedge mclk) disable iff (!rst_b)
        lk.strobe_rise |-> !port_data_oe ##1 !port_data_oe)
        else $error("bus still driven after strobe rise");

    chk_drive_reads: assert property (@(posedge mclk) disable iff (!rst_b)
        port_data_oe |-> (q.st == ST_FETCH || q.st == ST_RD))
        else $error("bus driven outside a read");

    chk_data_before_rdy: assert property (@(posedge mclk) disable iff (!rst_b)
        ($fell(host_ready_n) && q.st == ST_RD) |->
            port_data_out == out_view(q.data, q.m16, q.hw))
        else $error("ready low without valid read data");

    chk_second_half: assert property (@(posedge mclk) disable iff (!rst_b)
        (q.st == ST_IDLE && lk.strobe_fall && lk.sel_rnw && lk.mode16 &&
         lk.sel_hw) |-> ##[1:RDY2_MAX] (!host_ready_n && !fetch_req))
        else $error("second half read late or fetched again");

    chk_word_store: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(store_valid) |-> !$past(q.m16) || $past(q.hw))
        else $error("store issued on first half word");

    cov_word_read: cover property (@(posedge mclk) disable iff (!rst_b)
        fetch_req && fetch_ack && !q.m16);
    cov_half_read: cover property (@(posedge mclk) disable iff (!rst_b)
        q.st == ST_RD && q.m16 && q.hw);
    cov_full_stall: cover property (@(posedge mclk) disable iff (!rst_b)
        q.st == ST_WR_WAIT && host_ready_n ##1 !host_ready_n);
    cov_store: cover property (@(posedge mclk) disable iff (!rst_b)
        store_valid && store_ready);

endmodule
`default_nettype wire

// *** design/hpsh_pin_sync.sv ***
// Pin synchroniser and combined access strobe former.
// Assumes all host pins are asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module hpsh_pin_sync (
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst_b,
    // Raw host pins
    input  wire logic [hpsh_pkg::PIN_W-1:0] pins,
    // Synchronised view
    hpsh_link_if.sync                     lk
);
    import hpsh_pkg::*;

    typedef struct packed {
        logic [PIN_W-1:0] meta;
        logic [PIN_W-1:0] sync;
        logic             strb_n;
        logic             as_n;
        logic             held;
        logic [3:0]       sel;
    } hpsh_sync_s;

    hpsh_sync_s q;
    hpsh_sync_s d;
    logic       strb_n;
    logic [3:0] cur_sel;
    logic [3:0] eff_sel;

    // ****************************************
    // Strobe forming and select capture
    // ****************************************
    always_comb begin
        strb_n  = ~(q.sync[PIN_DS1] ^ q.sync[PIN_DS2]) | q.sync[PIN_CS];
        cur_sel = {q.sync[PIN_ACF+1], q.sync[PIN_ACF], q.sync[PIN_RNW],
                   q.sync[PIN_HWS]};
        eff_sel = q.held ? q.sel : cur_sel;
        d       = q;
        d.meta  = pins;
        d.sync  = q.meta;
        d.strb_n = strb_n;
        d.as_n  = q.sync[PIN_AS];
        if (!q.strb_n && strb_n) begin
            d.held = 1'b0;
        end
        if (q.as_n && !q.sync[PIN_AS]) begin
            d.held = 1'b1;
            d.sel  = cur_sel;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{meta: PIN_IDLE, sync: PIN_IDLE, strb_n: 1'b1,
                   as_n: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    assign lk.strobe_fall = q.strb_n & ~strb_n;
    assign lk.strobe_rise = ~q.strb_n & strb_n;
    assign lk.strobe_low  = ~strb_n;
    assign lk.sel_acf     = eff_sel[3:2];
    assign lk.sel_rnw     = eff_sel[1];
    assign lk.sel_hw      = eff_sel[0];
    assign lk.mode16      = q.sync[PIN_MODE];
    assign lk.wdata       = q.sync[PIN_DATA +: DATA_W];

    // ****************************************
    // Checks
    // ****************************************
    chk_strobe_form: assert property (@(posedge mclk) disable iff (!rst_b)
        lk.strobe_fall |-> !q.sync[PIN_CS] &&
            (q.sync[PIN_DS1] != q.sync[PIN_DS2]) && $past(lk.strobe_low) == 1'b0)
        else $error("strobe fell without select and differing data strobes");

endmodule
`default_nettype wire

// *** shared/hpsh_link_if.sv ***
// Synchronised host strobe events and select lines.
// Assumes driver and receiver share mclk.
`timescale 1ns/1ps
`default_nettype none
interface hpsh_link_if;
    import hpsh_pkg::*;
    logic              strobe_fall;
    logic              strobe_rise;
    logic              strobe_low;
    logic              sel_rnw;
    logic [1:0]        sel_acf;
    logic              sel_hw;
    logic              mode16;
    logic [DATA_W-1:0] wdata;

    modport sync (output strobe_fall, strobe_rise, strobe_low, sel_rnw,
                  sel_acf, sel_hw, mode16, wdata);
    modport core (input strobe_fall, strobe_rise, strobe_low, sel_rnw,
                  sel_acf, sel_hw, mode16, wdata);
endinterface
`default_nettype wire

// *** shared/hpsh_pkg.sv ***
// Constants, types and decode helpers of the host port strobe handshake.
// Assumes a single 250 MHz core clock; host pins arrive asynchronously.
package hpsh_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int HIZ_MAX_PS    = 12000;
    localparam int HIZ_CYC       = HIZ_MAX_PS / CLK_PERIOD_PS;
    localparam int HALF2_MAX_PS  = 4 * CLK_PERIOD_PS + 8000;
    localparam int HALF2_CYC     = HALF2_MAX_PS / CLK_PERIOD_PS;
    localparam int SYNC_LAT      = 2;

    // ****************************************
    // Widths and pin vector layout
    // ****************************************
    localparam int DATA_W      = 32;
    localparam int HALF_W      = 16;
    localparam int PIN_DATA    = 0;
    localparam int PIN_CS      = 32;
    localparam int PIN_DS1     = 33;
    localparam int PIN_DS2     = 34;
    localparam int PIN_AS      = 35;
    localparam int PIN_RNW     = 36;
    localparam int PIN_HWS     = 37;
    localparam int PIN_MODE    = 38;
    localparam int PIN_ACF     = 39;
    localparam int PIN_W       = 41;
    localparam logic [PIN_W-1:0] PIN_IDLE = 41'h09_0000_0000;

    // ****************************************
    // Access control codes and reset values
    // ****************************************
    localparam logic [1:0]        ACF_DATA_INC = 2'h2;
    localparam logic [1:0]        ACF_DATA_FIX = 2'h3;
    localparam logic [DATA_W-1:0] DATA_RST     = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_RD,
        ST_WR_WAIT,
        ST_WR
    } hpsh_state_e;

    // Access targets the data register
    function automatic logic hpsh_is_data(input logic [1:0] acf);
        return (acf == ACF_DATA_INC) || (acf == ACF_DATA_FIX);
    endfunction

    // Access needs an internal fetch or store (whole word boundary)
    function automatic logic hpsh_word_edge(input logic m16,
                                            input logic hw,
                                            input logic first);
        return !m16 || (hw == !first);
    endfunction

endpackage

// *** test/hpsh_host_model.sv ***
// Host processor model for the strobe handshake port.
// Assumes the host moves its pins 1 ns after a rising mclk edge.
`timescale 1ns/1ps
`default_nettype none
module hpsh_host_model (
    // Clock
    input  wire logic        mclk,
    // Host pins
    output logic             cs_n,
    output logic             ds1,
    output logic             ds2,
    output logic             as_n,
    output logic [1:0]       acf,
    output logic             rnw,
    output logic             hws,
    output logic             m16,
    output logic [31:0]      bus,
    // Device answers
    input  wire logic [31:0] dout,
    input  wire logic        oe,
    input  wire logic        rdy_n
);
    logic        drv;
    logic [31:0] hdat;
    int          n_tmo;
    int          n_oe;

    // Released bus shows no stale value
    assign bus = drv ? hdat : (oe ? dout : ~hdat);

    initial begin
        {cs_n, ds1, ds2, as_n, acf, rnw, hws, m16} = 9'h130;
        {drv, hdat, n_tmo, n_oe} = '0;
    end

    // ****************************************
    // One access; a selects the address strobe and the data strobe used
    // ****************************************
    task automatic access(input logic r, input logic [1:0] c,
                          input logic h, input logic m, input logic a,
                          input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge mclk);
        #1;
        {rnw, acf, hws, m16, hdat, drv} = {r, c, h, m, wd, !r};
        @(posedge mclk);
        #1;
        as_n = !a;
        @(posedge mclk);
        #1;
        cs_n = 1'b0;
        if (a) ds2 = 1'b1;
        else ds1 = 1'b1;
        n = 0;
        while ((rdy_n !== 1'b0 || n < 4) && n < 200) begin
            @(posedge mclk);
            #1;
            as_n = 1'b1;
            n++;
        end
        if (n >= 200) n_tmo++;
        rd = bus;
        {cs_n, ds1, ds2} = 3'h4;
        @(posedge mclk);
        #1;
        drv = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        if (oe !== 1'b0) n_oe++;
        repeat (2) @(posedge mclk);
    endtask

    // Strobes differ while chip select is high: no access
    task automatic stray_strobe();
        @(posedge mclk);
        #1;
        {acf, rnw, ds1} = 4'hF;
        repeat (8) @(posedge mclk);
        #1;
        ds1 = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench of the host port strobe handshake.
// Assumes hpsh_core on mclk; the bench plays the dma and write buffer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import hpsh_pkg::*;
    logic        mclk, rst_b, cs_n, ds1, ds2, as_n, rnw, hws, m16;
    logic        oe, rdy_n, fetch_req, fetch_ack, store_valid, store_ready;
    logic [1:0]  acf;
    logic [31:0] bus, dout, fetch_data, store_data, rd, wd, w1;
    logic [31:0] fq[$];
    logic [31:0] sq[$];
    int          seed, n_errors, cmp_count, n_fetch, w0, i;
    logic        sr_en;

    hpsh_core DUT (.mclk(mclk), .rst_b(rst_b), .host_chip_select_n(cs_n),
        .data_strobe_one(ds1), .data_strobe_two(ds2), .addr_strobe_n(as_n),
        .access_control_field(acf), .read_not_write(rnw),
        .half_word_select(hws), .half_width_mode(m16), .port_data_in(bus),
        .port_data_out(dout), .port_data_oe(oe), .host_ready_n(rdy_n),
        .fetch_req(fetch_req), .fetch_ack(fetch_ack),
        .fetch_data(fetch_data), .store_valid(store_valid),
        .store_ready(store_ready), .store_data(store_data));

    hpsh_host_model H (.mclk(mclk), .cs_n(cs_n), .ds1(ds1), .ds2(ds2),
        .as_n(as_n), .acf(acf), .rnw(rnw), .hws(hws), .m16(m16),
        .bus(bus), .dout(dout), .oe(oe), .rdy_n(rdy_n));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // ****************************************
    // Dma fetch answers and write buffer, random delays
    // ****************************************
    always @(posedge mclk) begin
        if (store_valid === 1'b1 && store_ready === 1'b1)
            sq.push_back(store_data);
        #1;
        fetch_ack <= 1'b0;
        store_ready <= sr_en & $random(seed);
        if (fetch_req === 1'b1 && fetch_ack !== 1'b1 && $random(seed) % 2) begin
            fetch_data <= $random(seed);
            fetch_ack  <= 1'b1;
        end
        if (fetch_ack === 1'b1) begin
            fq.push_back(fetch_data);
            n_fetch++;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic pop_store(output logic [31:0] v);
        int n;
        n = 0;
        while (sq.size() == 0 && n < 60) begin
            @(posedge mclk);
            n++;
        end
        v = sq.size() ? sq.pop_front() : 'x;
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #80000;
        n_errors++;
        stop_test();
    end

    initial begin
        {seed, n_errors, cmp_count, n_fetch} = {32'd30, 96'd0};
        {fetch_ack, fetch_data, store_ready, sr_en, rst_b} = {34'h0, 2'h2};
        repeat (10) @(posedge mclk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge mclk);
        for (i = 0; i < 8; i++) begin
            w0 = n_fetch;
            H.access(1'b1, {1'b1, i[0]}, 1'b0, 1'b0, i[1], '0, rd);
            chk("fetch count", w0 + 1, n_fetch);
            chk("read word", fq.pop_front(), rd);
        end
        $display("test word reads done");
        for (i = 0; i < 4; i++) begin
            w0 = n_fetch;
            H.access(1'b1, 2'h3, 1'b0, 1'b1, i[0], '0, rd);
            w1 = fq.pop_front();
            chk("first half", {16'h0, w1[15:0]}, rd);
            H.access(1'b1, 2'h3, 1'b1, 1'b1, i[1], '0, rd);
            chk("second half", {16'h0, w1[31:16]}, rd);
            chk("fetch per word", w0 + 1, n_fetch);
        end
        $display("test half reads done");
        for (i = 0; i < 8; i++) begin
            wd = $random(seed);
            H.access(1'b0, {1'b1, i[0]}, 1'b0, 1'b0, i[1], wd, rd);
            pop_store(w1);
            chk("store word", wd, w1);
        end
        for (i = 0; i < 4; i++) begin
            wd = $random(seed);
            H.access(1'b0, 2'h2, 1'b0, 1'b1, i[0], {16'h0, wd[15:0]}, rd);
            repeat (8) @(posedge mclk);
            chk("early store", 0, sq.size());
            H.access(1'b0, 2'h2, 1'b1, 1'b1, i[1], {16'h0, wd[31:16]}, rd);
            pop_store(w1);
            chk("half store", wd, w1);
        end
        $display("test writes done");
        sr_en = 1'b0;
        wd = $random(seed);
        fork
            H.access(1'b0, 2'h2, 1'b0, 1'b0, 1'b0, wd, rd);
            begin
                repeat (30) @(posedge mclk);
                #1;
                chk("ready while full", 1, rdy_n);
                sr_en = 1'b1;
            end
        join
        pop_store(w1);
        chk("held store", wd, w1);
        H.access(1'b0, 2'h3, 1'b0, 1'b0, 1'b1, ~wd, rd);
        pop_store(w1);
        chk("next store", ~wd, w1);
        $display("test full buffer done");
        w0 = n_fetch;
        H.access(1'b0, 2'h1, 1'b0, 1'b0, 1'b1, wd, rd);
        H.access(1'b1, 2'h0, 1'b0, 1'b0, 1'b0, '0, rd);
        chk("held view", ~wd, rd);
        H.stray_strobe();
        repeat (10) @(posedge mclk);
        chk("no fetch", w0, n_fetch);
        chk("no store", 0, sq.size());
        chk("handshake hangs", 0, H.n_tmo);
        chk("bus left driven", 0, H.n_oe);
        $display("test other codes done");
        stop_test();
    end
endmodule
`default_nettype wire
